/* pkg/ioc_pkg.sv */
// Shared constants and types for the I/O channel instruction handler
package ioc_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int WORD_W = 24; // Accumulator and channel word
	localparam int ADDR_W = 18; // Transfer address width
	localparam int PLIST_PA_W = 16; // Parameter-list channel address width
	localparam int UNIT_W = 4; // Full unit code
	localparam int STAT_W = 8; // Unit status lines
	localparam int CHAR8_W = 8; // Narrow unit interface
	localparam int WB_ADR_W = 8; // Decoded Wishbone address bits

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADR_ACC = 8'h00; // Accumulator image
	localparam logic [7:0] ADR_INSTR = 8'h04; // Instruction issue
	localparam logic [7:0] ADR_STATUS = 8'h08; // Channel state
	localparam logic [7:0] ADR_PAR = 8'h0C; // Parameter address

	// ----------------------------------------
	// Instruction word fields
	// ----------------------------------------
	localparam int OPC_LSB = 0; // Opcode, three bits
	localparam int OPC_W = 3;
	localparam int UNIT_LSB = 4; // Unit code, four bits
	localparam int MERGE_BIT = 8; // Character merge select

	// Command word fields
	localparam int MODE_LSB = 4; // Mode, bits 4 and 5
	localparam int MODE_W = 2;
	localparam int OVR_BIT = 6; // Override
	localparam int SWINT_SEL_W = 2; // One of four pulses

	// Status-input word channel bits
	localparam int ST_MUX = 21;
	localparam int ST_OFF = 22;
	localparam int ST_BLK = 23;
	localparam int NARROW_STAT_W = 6; // Six bits on 8-bit interface

	// STATUS register fields
	localparam int STS_COND = 0; // Condition not-zero
	localparam int STS_BUSY = 1;
	localparam int STS_OFF = 2;
	localparam int STS_MUX = 3;
	localparam int STS_UNIT_LSB = 4;

	// Default mode codes
	localparam logic [1:0] MC_NORMAL = 2'h0;
	localparam logic [1:0] MC_OFFLINE = 2'h1;
	localparam logic [1:0] MC_MUX = 2'h2;
	localparam logic [1:0] MC_RESET = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int SWINT_PULSE_NS = 1000;
	localparam int SWINT_CYCLES = SWINT_PULSE_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CH_PROG, CH_PLIST, CH_EXT, CH_TWO
	} ioc_chan_t;

	typedef enum logic [2:0] {
		OP_CMD_OUT = 3'h0, OP_STAT_IN = 3'h1, OP_DATA_IN = 3'h2,
		OP_DATA_OUT = 3'h3, OP_ADDR_OUT = 3'h4, OP_ADDR_IN = 3'h5,
		OP_PADDR_IN = 3'h6, OP_NONE = 3'h7
	} ioc_op_t;

	typedef enum logic [1:0] {
		KIND_CMD = 2'h0, KIND_DATA = 2'h1, KIND_WCOUNT = 2'h2, KIND_TADDR = 2'h3
	} ioc_kind_t;

	typedef enum logic [1:0] {
		MODE_NORMAL, MODE_OFFLINE, MODE_MUX
	} ioc_mode_t;

endpackage : ioc_pkg

/* rtl/ioc_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module ioc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_reg; // Metastable stage, read by s2 only
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	// ----------------------------------------
	// Shift chain
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Accept a change only once the last two stages agree
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			level_o <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					level_o[i] <= s3_reg[i];
				end
			end
		end
	end

endmodule : ioc_sync

/* rtl/ioc_pulse_gen.sv */
// Fixed-length pulse generator for one software interrupt line
`timescale 1ns/1ns
module ioc_pulse_gen #(
	parameter int CYCLES = 10
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Trigger and pulse
	input wire logic trig_i,
	output logic pulse_o
);
	localparam int CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);

	logic [CNT_W-1:0] cnt_reg; // Cycles still to drive

	// ----------------------------------------
	// Count down; a new trigger restarts the pulse
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			cnt_reg <= '0;
		end else if (trig_i) begin
			cnt_reg <= CNT_LOAD;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// Registered so the line is glitch free
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pulse_o <= 1'b0;
		end else begin
			pulse_o <= trig_i || (cnt_reg > CNT_W'(1));
		end
	end

endmodule : ioc_pulse_gen

/* rtl/ioc_channel.sv */
// I/O channel instruction handler with Wishbone register access
//
// Function
// R1 - Busy command output refused, condition not-zero
// R2 - Override forces reconnect, clears activity (code does neither in offline mode)
// R3 - Unit code width depends on channel type
// R4 - Command bits 4-5 select channel mode
// R5 - Mode code mapping is configurable
// R6 - Offline mode detaches units from interface
// R7 - Multiplex ignores CPU except override/reset
// R8 - Reset mode returns to normal
// R9 - Two-unit channel stays in normal mode
// R10 - Status word packs unit status low
// R11 - Channel mode and busy in top bits
// R12 - Data input immediate else not-zero
// R13 - Input character right-justified, upper zeros
// R14 - Merge ORs input into accumulator
// R15 - Data input unsupported on ext/two-unit
// R16 - Output word buffered until unit takes
// R17 - Ext sends word count; two-unit refuses
// R18 - Address output loads parameter address register
// R19 - Param-list address output clears block logic
// R20 - Ext refuses address output while busy
// R21 - Two-unit stores address per unit
// R22 - Programmed channel emits software interrupt pulse
// R23 - Address input returns 18-bit transfer address
// R24 - Unit change reconnects, busy meanwhile
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module ioc_channel
	import ioc_pkg::*;
#(
	parameter ioc_chan_t CHAN_TYPE = CH_PROG,
	parameter int OUT_W = WORD_W, // 8 or 24
	parameter int CHAR_W = WORD_W, // Bits per input character
	parameter logic [1:0] MODE_CODE_OFF = MC_OFFLINE,
	parameter logic [1:0] MODE_CODE_MUX = MC_MUX,
	parameter logic [1:0] MODE_CODE_RST = MC_RESET
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Unit selection
	output logic [UNIT_W-1:0] unit_sel_o,
	output logic unit_connect_o,
	input wire logic unit_connected_i,
	// Unit input
	input wire logic unit_data_avail_i,
	input wire logic [WORD_W-1:0] unit_data_i,
	output logic unit_data_ack_o,
	input wire logic [STAT_W-1:0] unit_status_i,
	input wire logic [ADDR_W-1:0] transfer_address_i,
	input wire logic block_busy_i,
	// Unit output
	output logic [WORD_W-1:0] out_word_o,
	output logic [1:0] out_kind_o,
	output logic out_valid_o,
	input wire logic unit_take_i,
	// Channel state
	output logic offline_o,
	output logic multiplex_o,
	output logic block_clear_o,
	output logic [ADDR_W-1:0] param_address_o,
	output logic [3:0] swint_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE, ST_DROP, ST_RAISE, ST_OUT
	} ioc_state_t;

	// Unit-code mask per channel type
	localparam logic [UNIT_W-1:0] UMASK =
		(CHAN_TYPE == CH_TWO) ? 4'h3 : (CHAN_TYPE == CH_EXT) ? 4'h7 : 4'hF; // R3

	ioc_state_t state_reg; // Channel sequencer
	ioc_mode_t mode_reg; // Current channel mode
	logic [WORD_W-1:0] acc_reg; // Accumulator image
	logic cond_reg; // Condition not-zero
	logic [WORD_W-1:0] obuf_reg; // Output buffer
	logic [1:0] okind_reg; // What the buffer holds
	logic pend_reg; // Buffer waits for reconnect
	logic [UNIT_W-1:0] unit_reg; // Connected unit
	logic [UNIT_W-1:0] new_unit_reg; // Unit being connected
	logic [ADDR_W-1:0] par_reg; // Parameter address
	logic [ADDR_W-1:0] par_unit_reg [2]; // Two-unit storage
	logic take_d_reg; // Previous synced take
	logic [3:0] sw_trig; // Software interrupt triggers
	logic [3:0] pin_s; // Synchronised pins
	logic conn_s, avail_s, take_s, blk_s;

	// Instruction decode
	logic exec;
	ioc_op_t op;
	logic [UNIT_W-1:0] iunit;
	logic merge, ovr, busy, same_unit, mux_block;
	logic [1:0] mcode;
	logic [WORD_W-1:0] in_char, stat_word;
	logic [31:0] rd_data;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	ioc_sync #(.WIDTH(4)) u_sync (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.pin_i({block_busy_i, unit_take_i, unit_data_avail_i, unit_connected_i}),
		.level_o(pin_s)
	);
	assign {blk_s, take_s, avail_s, conn_s} = pin_s;

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	// An instruction runs at the edge where the INSTR write is acknowledged
	assign exec = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
		(wb_adr_i == ADR_INSTR) && wb_sel_i[0];
	assign op = ioc_op_t'(wb_dat_i[OPC_LSB +: OPC_W]);
	assign iunit = wb_dat_i[UNIT_LSB +: UNIT_W] & UMASK; // R3
	assign merge = wb_dat_i[MERGE_BIT];
	// Override does not exist on the external-addressing channel
	assign ovr = acc_reg[OVR_BIT] && (CHAN_TYPE != CH_EXT); // R2
	assign mcode = acc_reg[MODE_LSB +: MODE_W]; // R4 R5
	assign busy = (state_reg != ST_IDLE);
	assign same_unit = (iunit == unit_reg);
	// Multiplex shuts out the CPU except override or a reset command
	assign mux_block = (mode_reg == MODE_MUX) &&
		!((op == OP_CMD_OUT) && (ovr || (mcode == MODE_CODE_RST))); // R7

	// Character right-justified, unused upper bits zero
	assign in_char = WORD_W'(unit_data_i[CHAR_W-1:0]); // R13

	// ----------------------------------------
	// Status word packing
	// ----------------------------------------
	always_comb begin
		stat_word = '0;
		if (OUT_W == CHAR8_W) begin
			stat_word[NARROW_STAT_W-1:0] = unit_status_i[NARROW_STAT_W-1:0]; // R10
		end else begin
			stat_word[STAT_W-1:0] = unit_status_i; // R10
		end
		if (CHAN_TYPE == CH_PROG || CHAN_TYPE == CH_PLIST) begin
			stat_word[ST_MUX] = (mode_reg == MODE_MUX); // R11
		end
		if (CHAN_TYPE != CH_TWO) begin
			stat_word[ST_OFF] = (mode_reg == MODE_OFFLINE); // R11
		end
		if (CHAN_TYPE == CH_PLIST) begin
			stat_word[ST_BLK] = blk_s; // R11
		end
	end

	// ----------------------------------------
	// Sequencer: reconnect and output buffer
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state_reg <= ST_IDLE;
			pend_reg <= 1'b0;
			unit_reg <= '0;
			new_unit_reg <= '0;
		end else if (exec && op == OP_CMD_OUT && ovr && !(mode_reg == MODE_OFFLINE)) begin
			// Override drops whatever runs and reconnects the unit
			state_reg <= ST_DROP; // R2
			new_unit_reg <= iunit;
			pend_reg <= 1'b1;
		end else if (exec && !busy && !mux_block && !same_unit &&
				op != OP_ADDR_IN && op != OP_PADDR_IN && mode_reg != MODE_OFFLINE) begin
			// Different unit: reconnect first, instruction must be retried
			state_reg <= ST_DROP; // R24
			new_unit_reg <= iunit;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (exec && same_unit && !mux_block && obuf_load(op)) begin
						state_reg <= ST_OUT; // R16
					end
				end
				ST_DROP: begin
					// Old unit must let go before the new one is asked for
					if (!conn_s) begin
						state_reg <= ST_RAISE;
						unit_reg <= new_unit_reg;
					end
				end
				ST_RAISE: begin
					if (conn_s) begin
						state_reg <= pend_reg ? ST_OUT : ST_IDLE;
						pend_reg <= 1'b0;
					end
				end
				ST_OUT: begin
					// Buffer freed on the unit's take edge
					if (take_s && !take_d_reg) begin
						state_reg <= ST_IDLE; // R16
					end
				end
			endcase
		end
	end

	// Whether an instruction accepted in idle fills the output buffer
	function automatic logic obuf_load(input ioc_op_t o);
		logic r;
		r = 1'b0;
		if (o == OP_CMD_OUT) begin
			r = 1'b1;
		end else if (o == OP_DATA_OUT) begin
			r = (CHAN_TYPE != CH_TWO); // R17
		end else if (o == OP_ADDR_OUT) begin
			r = (CHAN_TYPE == CH_EXT); // R20
		end
		return r;
	endfunction : obuf_load

	// Take edge tracking
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			take_d_reg <= 1'b0;
		end else begin
			take_d_reg <= take_s;
		end
	end

	// ----------------------------------------
	// Output buffer contents
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			obuf_reg <= '0;
			okind_reg <= KIND_CMD;
		end else if (exec && op == OP_CMD_OUT && (ovr || (!busy && !mux_block))) begin
			obuf_reg <= acc_reg;
			okind_reg <= KIND_CMD;
		end else if (exec && !busy && same_unit && !mux_block) begin
			if (op == OP_DATA_OUT && CHAN_TYPE != CH_TWO) begin
				// Narrow interface passes only the low byte
				obuf_reg <= WORD_W'(acc_reg[OUT_W-1:0]); // R16
				okind_reg <= (CHAN_TYPE == CH_EXT) ? KIND_WCOUNT : KIND_DATA; // R17
			end else if (op == OP_ADDR_OUT && CHAN_TYPE == CH_EXT) begin
				obuf_reg <= WORD_W'(acc_reg[ADDR_W-1:0]); // R20
				okind_reg <= KIND_TADDR;
			end
		end
	end

	// ----------------------------------------
	// Channel mode
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			mode_reg <= MODE_NORMAL;
		end else if (exec && op == OP_CMD_OUT && CHAN_TYPE != CH_TWO && // R9
				(ovr || (!busy && !mux_block && same_unit))) begin
			if (mcode == MODE_CODE_RST) begin
				mode_reg <= MODE_NORMAL; // R8
			end else if (mcode == MODE_CODE_OFF) begin
				mode_reg <= MODE_OFFLINE; // R4
			end else if (mcode == MODE_CODE_MUX) begin
				mode_reg <= MODE_MUX; // R4
			end
		end
	end

	// ----------------------------------------
	// Accumulator image and condition
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			acc_reg <= '0;
			cond_reg <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADR_ACC) begin
			for (int b = 0; b < 3; b++) begin
				if (wb_sel_i[b]) begin
					acc_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end else if (exec) begin
			cond_reg <= 1'b1; // Refusal is the default answer
			if (op == OP_CMD_OUT) begin
				cond_reg <= !(ovr || (!busy && !mux_block && same_unit)); // R1
			end else if (mux_block || ((busy || !same_unit) && op != OP_ADDR_IN &&
					op != OP_PADDR_IN) || (busy && CHAN_TYPE == CH_TWO)) begin
				cond_reg <= 1'b1; // R1
			end else begin
				unique case (op)
					OP_STAT_IN: begin
						acc_reg <= stat_word; // R10
						cond_reg <= 1'b0;
					end
					OP_DATA_IN: begin
						if (CHAN_TYPE != CH_EXT && CHAN_TYPE != CH_TWO && avail_s) begin // R15
							acc_reg <= merge ? (acc_reg | in_char) : in_char; // R12 R14
							cond_reg <= 1'b0;
						end
					end
					OP_DATA_OUT: cond_reg <= (CHAN_TYPE == CH_TWO); // R17
					OP_ADDR_OUT: cond_reg <= 1'b0; // R18
					OP_ADDR_IN: begin
						if (CHAN_TYPE != CH_EXT) begin
							acc_reg <= WORD_W'(transfer_address_i); // R23
							cond_reg <= 1'b0;
						end
					end
					OP_PADDR_IN: begin
						if (CHAN_TYPE == CH_TWO) begin
							acc_reg <= WORD_W'(par_unit_reg[iunit[0]]);
							cond_reg <= 1'b0;
						end else if (CHAN_TYPE == CH_PLIST) begin
							acc_reg <= WORD_W'(par_reg[PLIST_PA_W-1:0]);
							cond_reg <= 1'b0;
						end
					end
					default: cond_reg <= 1'b1;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Address output: parameter address registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			par_reg <= '0;
			par_unit_reg[0] <= '0;
			par_unit_reg[1] <= '0;
		end else if (exec && op == OP_ADDR_OUT && !busy && !mux_block && same_unit) begin
			if (CHAN_TYPE == CH_PLIST) begin
				par_reg <= acc_reg[ADDR_W-1:0]; // R18
			end else if (CHAN_TYPE == CH_TWO) begin
				par_reg <= acc_reg[ADDR_W-1:0]; // R18
				par_unit_reg[iunit[0]] <= acc_reg[ADDR_W-1:0]; // R21
			end
		end
	end

	// Block clear and software interrupt triggers
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			block_clear_o <= 1'b0;
			sw_trig <= '0;
		end else begin
			block_clear_o <= exec && op == OP_ADDR_OUT && CHAN_TYPE == CH_PLIST &&
				!busy && !mux_block && same_unit; // R19
			sw_trig <= '0;
			if (exec && op == OP_ADDR_OUT && CHAN_TYPE == CH_PROG &&
					!busy && !mux_block && same_unit) begin
				sw_trig[acc_reg[SWINT_SEL_W-1:0]] <= 1'b1; // R22
			end
		end
	end

	// One generator per software interrupt line
	for (genvar g = 0; g < 4; g++) begin : g_swint
		ioc_pulse_gen #(.CYCLES(SWINT_CYCLES)) u_pulse (
			.core_clk_i(core_clk_i),
			.reset_n_i(reset_n_i),
			.trig_i(sw_trig[g]),
			.pulse_o(swint_o[g]) // R22
		);
	end

	// Data input handshake back to the unit
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			unit_data_ack_o <= 1'b0;
		end else begin
			unit_data_ack_o <= exec && op == OP_DATA_IN && !busy && !mux_block &&
				same_unit && avail_s && CHAN_TYPE != CH_EXT && CHAN_TYPE != CH_TWO;
		end
	end

	// ----------------------------------------
	// Unit-side outputs
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			unit_sel_o <= '0;
			unit_connect_o <= 1'b0;
			out_word_o <= '0;
			out_kind_o <= KIND_CMD;
			out_valid_o <= 1'b0;
		end else begin
			unit_sel_o <= unit_reg;
			// Offline detaches the units; drop also releases them
			unit_connect_o <= (state_reg != ST_DROP) && (unit_sel_o == unit_reg) &&
				(mode_reg != MODE_OFFLINE); // R6 R24
			out_word_o <= obuf_reg;
			out_kind_o <= okind_reg;
			out_valid_o <= (state_reg == ST_OUT) && !(take_s && !take_d_reg);
		end
	end
	assign offline_o = (mode_reg == MODE_OFFLINE); // R6
	assign multiplex_o = (mode_reg == MODE_MUX);
	assign param_address_o = par_reg;

	// ----------------------------------------
	// Wishbone slave: registered answer one cycle after the request
	// ----------------------------------------
	always_comb begin
		rd_data = '0;
		unique case (wb_adr_i)
			ADR_ACC: rd_data = 32'(acc_reg);
			ADR_STATUS: begin
				rd_data[STS_COND] = cond_reg;
				rd_data[STS_BUSY] = busy;
				rd_data[STS_OFF] = (mode_reg == MODE_OFFLINE);
				rd_data[STS_MUX] = (mode_reg == MODE_MUX);
				rd_data[STS_UNIT_LSB +: UNIT_W] = unit_reg;
			end
			ADR_PAR: rd_data = 32'(par_reg);
			default: rd_data = '0; // Unmapped and INSTR read as zero
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_data;
		end
	end

endmodule : ioc_channel

/* verification/ioc_channel_asserts.sv */
// Port-level checker for the I/O channel instruction handler
`timescale 1ns/1ns
module ioc_channel_chk
	import ioc_pkg::*;
(
	// Clock, reset and bus
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Unit side
	input wire logic [UNIT_W-1:0] unit_sel_o,
	input wire logic unit_connect_o,
	input wire logic unit_data_ack_o,
	input wire logic [WORD_W-1:0] out_word_o,
	input wire logic out_valid_o,
	input wire logic unit_take_i,
	// Channel state
	input wire logic offline_o,
	input wire logic multiplex_o,
	input wire logic [3:0] swint_o
);
	// ----------------------------------------
	// Handshakes, buffer and pulses
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Slave answers one cycle after a taken request
	chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
	chk_data_ack_pulse: assert property (unit_data_ack_o |=> !unit_data_ack_o)
		else $error("data ack too long");
	// Word must not move while the unit may be sampling it
	chk_out_stable: assert property (out_valid_o && $past(out_valid_o) |-> $stable(out_word_o))
		else $error("output word moved");
	chk_out_waits: assert property (out_valid_o && !unit_take_i |=> out_valid_o)
		else $error("buffer freed without take");
	chk_take_frees: assert property ($rose(unit_take_i) |-> ##[1:8] !out_valid_o)
		else $error("buffer not freed");
	chk_mode_single: assert property (!(offline_o && multiplex_o))
		else $error("two modes at once");
	// Selection may only move while disconnected
	chk_sel_disconn: assert property ($changed(unit_sel_o) |-> !unit_connect_o)
		else $error("unit changed while connected");
	chk_swint_width: assert property ($rose(|swint_o) |-> ##9 (|swint_o) ##1 !(|swint_o))
		else $error("interrupt pulse length");
	chk_swint_onehot: assert property ($onehot0(swint_o))
		else $error("several interrupt pulses");
endmodule : ioc_channel_chk

bind ioc_channel ioc_channel_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .unit_sel_o(unit_sel_o),
	.unit_connect_o(unit_connect_o), .unit_data_ack_o(unit_data_ack_o),
	.out_word_o(out_word_o), .out_valid_o(out_valid_o), .unit_take_i(unit_take_i),
	.offline_o(offline_o), .multiplex_o(multiplex_o), .swint_o(swint_o));

/* verification/ioc_unit_model.sv */
// Behavioural peripheral unit on the channel's far side
`timescale 1ns/1ns
module ioc_unit_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// From channel
	input wire logic connect_i,
	input wire logic out_valid_i,
	input wire logic data_ack_i,
	// Bench controls
	input wire logic stall_i,
	input wire logic give_i,
	input wire logic [23:0] word_i,
	// To channel
	output logic connected_o,
	output logic take_o,
	output logic avail_o,
	output logic [23:0] data_o
);
	// ----------------------------------------
	// Connection, output take, input data
	// ----------------------------------------
	logic [1:0] dly_reg; // Connect answer lags two cycles
	logic [23:0] held_reg; // Last input word
	assign connected_o = dly_reg[1];
	// Stale data is inverted so nothing relies on a leftover value
	assign data_o = avail_o ? held_reg : ~held_reg;
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) dly_reg <= 2'h0;
		else dly_reg <= {dly_reg[0], connect_i};
	end
	// Take held until the buffer frees, dropped before the next word
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || !out_valid_i) take_o <= 1'b0;
		else if (!stall_i) take_o <= 1'b1;
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			avail_o <= 1'b0;
			held_reg <= 24'h0;
		end else if (give_i) begin
			avail_o <= 1'b1;
			held_reg <= word_i;
		end else if (data_ack_i) avail_o <= 1'b0;
	end
endmodule : ioc_unit_model

/* verification/ioc_channel_tb_top.sv */
// Self-checking bench for the I/O channel instruction handler
`timescale 1ns/1ns
module ioc_channel_tb_top
	import ioc_pkg::*;
;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, stall = 0, give = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rd, wb_dat_o;
	logic [23:0] word = 24'h0, udat, out_word_o;
	logic wb_ack_o, conn, conn_i, take, avail, dack, ovalid, offl, mux, bclr;
	logic [3:0] usel, swint_o;
	logic [1:0] okind;
	logic [17:0] par;
	int failures = 0, checks = 0, n;
	logic [23:0] row_acc [5] = '{24'h000010, 24'h000030, 24'h000020, 24'h000040, 24'h000030};
	logic [31:0] row_exp [5] = '{32'h4, 32'h0, 32'h8, 32'h8, 32'h0};
	ioc_channel dut (.core_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .unit_sel_o(usel), .unit_connect_o(conn),
		.unit_connected_i(conn_i), .unit_data_avail_i(avail), .unit_data_i(udat),
		.unit_data_ack_o(dack), .unit_status_i(8'h2A), .transfer_address_i(18'h2ABCD),
		.block_busy_i(1'b0), .out_word_o(out_word_o), .out_kind_o(okind),
		.out_valid_o(ovalid), .unit_take_i(take), .offline_o(offl), .multiplex_o(mux),
		.block_clear_o(bclr), .param_address_o(par), .swint_o(swint_o));
	ioc_unit_model u_unit (.core_clk_i(clk), .reset_n_i(rst_n), .connect_i(conn),
		.out_valid_i(ovalid), .data_ack_i(dack), .stall_i(stall), .give_i(give),
		.word_i(word), .connected_o(conn_i), .take_o(take), .avail_o(avail), .data_o(udat));
	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		if (failures == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	// Classic cycle: request held until ack is sampled, then released
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0; stb <= 1'b0;
	endtask : wb
	task automatic instr(input logic [2:0] op, input logic [3:0] u, input logic m);
		wb(1'b1, ADR_INSTR, {23'h0, m, u, 1'b0, op});
	endtask : instr
	// Poll until the channel reports not busy, bounded
	task automatic wait_idle();
		for (int k = 0; k < 40; k++) begin
			wb(1'b0, ADR_STATUS, 32'h0);
			if (rd[STS_BUSY] === 1'b0) break;
		end
	endtask : wait_idle
	initial begin
		#3000000;
		failures++;
		print_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		wb(1'b0, ADR_STATUS, 32'h0);
		cmp(rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0); // Unmapped reads as zero
		cmp(rd, 32'h0);
		// Mode table: command, then mode flags with condition clear
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, ADR_ACC, {8'h0, row_acc[i]});
			instr(OP_CMD_OUT, 4'h0, 1'b0);
			wait_idle();
			cmp(rd & 32'h0F, row_exp[i]);
			if (i == 2) begin
				instr(OP_DATA_OUT, 4'h0, 1'b0);
				repeat (6) @(negedge clk);
				cmp({31'h0, ovalid}, 32'h0);
			end
		end
		// Data input: refused, replaced, merged
		instr(OP_DATA_IN, 4'h0, 1'b0);
		wb(1'b0, ADR_STATUS, 32'h0);
		cmp({31'h0, rd[STS_COND]}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, ADR_ACC, i ? 32'h123000 : 32'hFFF000);
			@(posedge clk) begin give <= 1'b1; word <= 24'h000ABC; end
			@(posedge clk) give <= 1'b0;
			repeat (8) @(posedge clk);
			instr(OP_DATA_IN, 4'h0, i[0]);
			wb(1'b0, ADR_ACC, 32'h0);
			cmp(rd, i ? 32'h123ABC : 32'h000ABC);
			repeat (8) @(posedge clk);
		end
		wb(1'b1, ADR_ACC, 32'h0);
		instr(OP_STAT_IN, 4'h0, 1'b0);
		wb(1'b0, ADR_ACC, 32'h0);
		cmp(rd, 32'h00002A);
		// Data output held while the unit stalls; second request refused
		stall <= 1'b1;
		wb(1'b1, ADR_ACC, 32'hC3A5A5);
		instr(OP_DATA_OUT, 4'h0, 1'b0);
		repeat (4) @(negedge clk);
		cmp({ovalid, okind, out_word_o}, {1'b1, KIND_DATA, 24'hC3A5A5});
		instr(OP_CMD_OUT, 4'h0, 1'b0);
		wb(1'b0, ADR_STATUS, 32'h0);
		cmp({31'h0, rd[STS_COND]}, 32'h1);
		stall <= 1'b0;
		n = 0;
		while (ovalid !== 1'b0 && n++ < 20) @(negedge clk);
		wait_idle();
		cmp({31'h0, rd[STS_BUSY]}, 32'h0);
		// Software interrupt pulse on select two
		wb(1'b1, ADR_ACC, 32'h2);
		instr(OP_ADDR_OUT, 4'h0, 1'b0);
		n = 0;
		repeat (30) @(negedge clk) if (swint_o === 4'h4) n++;
		cmp(n, SWINT_CYCLES);
		// Unit change: first try refused, reconnect, retry accepted
		wb(1'b1, ADR_ACC, 32'h0);
		instr(OP_CMD_OUT, 4'h5, 1'b0);
		wb(1'b0, ADR_STATUS, 32'h0);
		cmp({31'h0, rd[STS_COND]}, 32'h1);
		wait_idle();
		cmp({28'h0, usel}, 32'h5);
		instr(OP_CMD_OUT, 4'h5, 1'b0);
		wait_idle();
		cmp(rd & 32'hF3, 32'h50);
		print_verdict();
	end
endmodule : ioc_channel_tb_top
